/* core/bmu_params.svh */
// Constants of the bit manipulation unit: codes, bit positions, widths and register offsets.
`ifndef BMU_PARAMS_SVH
`define BMU_PARAMS_SVH

// Datapath geometry.
`define BMU_W             36
`define BMU_SIGN_POS      35
`define BMU_GUARD_LO      31
`define BMU_SHIFT_LIMIT   17'd36
`define BMU_LRS_TOP       31
`define BMU_FIELD_LIMIT   9'd36
`define BMU_FIELD_FULL    8'd36
`define BMU_EXP_BIAS      16'd5

// Instruction word layout.
`define BMU_TYPE_CODE     5'h1e

// Status word bit positions.
`define BMU_PSW_NEG_BIT   15
`define BMU_PSW_ZERO_BIT  14
`define BMU_PSW_LOST_BIT  13
`define BMU_PSW_GUARD_BIT 12
`define BMU_ALF_NOT1_BIT  7
`define BMU_ALF_ONES_BIT  6
`define BMU_ALF_EVEN_BIT  5
`define BMU_ALF_ODD_BIT   4

// Wishbone byte offsets.
`define BMU_ADR_INSTR     8'h00
`define BMU_ADR_IMM       8'h04
`define BMU_ADR_ACC       8'h08
`define BMU_ADR_ALT       8'h18
`define BMU_ADR_AR        8'h28
`define BMU_ADR_PSW       8'h38
`define BMU_ADR_ALF       8'h3c

`endif

/* core/bmu_pkg.sv */
// Types shared by the bit manipulation unit.
package bmu_pkg;

  // Operation classes decoded from the instruction word.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SHIFT,
    OP_EXP,
    OP_NORM,
    OP_EXTRACT,
    OP_INSERT,
    OP_SHUFFLE
  } bmu_op_t;

  typedef logic [35:0] bmu_word_t;

endpackage

/* core/bmu_unit.sv */
// Bit manipulation unit: barrel shifter, exponent, field ops and shuffle behind Wishbone.
`include "bmu_params.svh"
`timescale 1ns/1ns
`default_nettype none

module bmu_unit (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Condition flags towards the core.
  output logic             shift_result_negative_o,
  output logic             shift_result_zero_o,
  output logic             shift_bits_lost_o,
  output logic             shift_guard_overflow_o,
  output logic             even_parity_flag_o,
  output logic             odd_parity_flag_o,
  output logic             all_ones_flag_o,
  output logic             not_all_ones_flag_o
);
  import bmu_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Signed barrel shift; returns {lost, result}.
  function automatic logic [36:0] bmu_shift(input bmu_word_t v, input logic [15:0] cnt,
                                            input logic left, input logic logical);
    logic [16:0] mag;
    logic        dir_left;
    bmu_word_t   r;
    logic        lost;
    mag      = cnt[15] ? (17'h0 - {cnt[15], cnt}) : {1'b0, cnt};
    dir_left = left ^ cnt[15];
    if (dir_left) begin
      r = (mag >= `BMU_SHIFT_LIMIT) ? '0 : (v << mag);
      if (mag >= `BMU_SHIFT_LIMIT) begin
        lost = |v;
      end else if (logical) begin
        lost = ((r >> mag) != v);
      end else begin
        lost = (($signed(r) >>> mag) != $signed(v));
      end
    end else begin
      if (logical) begin
        r = {4'h0, v[`BMU_LRS_TOP:0]} >> mag;
      end else begin
        r = $signed(v) >>> mag;
      end
      lost = (mag >= `BMU_SHIFT_LIMIT);
    end
    return {lost, r};
  endfunction

  // Exponent: count of equal bits from the top, less the guard bias.
  function automatic logic [15:0] bmu_exp(input bmu_word_t v);
    logic       run;
    logic [5:0] k;
    k   = 6'd1;
    run = 1'b1;
    for (int i = `BMU_SIGN_POS - 1; i >= 0; i--) begin
      if (run && (v[i] == v[`BMU_SIGN_POS])) begin
        k = k + 6'd1;
      end else begin
        run = 1'b0;
      end
    end
    return {10'h0, k} - `BMU_EXP_BIAS;
  endfunction

  // Byte-lane merge for bus writes.
  function automatic logic [31:0] bmu_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      r[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bmu_word_t   acc_q [2];
  bmu_word_t   alt_q [2];
  logic [15:0] ar_q  [4];
  logic [15:0] instr_q;
  logic [15:0] imm_q;
  logic        go_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        neg_q, zero_q, lost_q, guard_q;
  logic        even_q, odd_q, ones_q, not_ones_q;
  logic        done_q;
  bmu_word_t   last_res_q;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  logic        dst, srci, alt_sel;
  logic [3:0]  f4, arf;
  bmu_op_t     op;
  bmu_word_t   src, oth, shv;
  logic [15:0] cnt, ctl;
  logic        left, logical, zext;

  assign dst     = instr_q[10];
  assign srci    = instr_q[9];
  assign f4      = {instr_q[8:6], instr_q[4]};
  assign arf     = instr_q[3:0];
  assign alt_sel = arf[0];
  assign src     = acc_q[srci];
  assign oth     = acc_q[~srci];
  assign left    = f4[0];
  assign logical = arf[3];

  // Unknown codes decode to no operation so stray words never corrupt state.
  always_comb begin
    op   = OP_NONE;
    shv  = src;
    cnt  = ar_q[arf[1:0]];
    ctl  = ar_q[arf[1:0]];
    zext = arf[2];
    if (instr_q[15:11] == `BMU_TYPE_CODE) begin
      unique case (f4)
        4'b0000, 4'b0001: begin
          if (arf[3:2] == 2'b11) begin
            if (f4[0]) begin
              op = OP_NORM;
            end else if (arf[1:0] == 2'b00) begin
              op = OP_EXP;
            end
          end else if (!arf[2]) begin
            op = OP_SHIFT;
          end
        end
        4'b1000, 4'b1001: begin
          if (arf[2:0] == 3'b000) begin
            op  = OP_SHIFT;
            shv = oth;
            cnt = src[31:16];
          end
        end
        4'b1100, 4'b1101: begin
          if (arf[2:0] == 3'b000) begin
            op  = OP_SHIFT;
            cnt = imm_q;
          end
        end
        4'b1110: begin
          ctl = imm_q;
          if (!arf[3] && (arf[1:0] == 2'b00)) begin
            op = OP_EXTRACT;
          end else if (arf == 4'b1000) begin
            op = OP_INSERT;
          end
        end
        4'b0010: begin
          if (!arf[3]) begin
            op = OP_EXTRACT;
          end
        end
        4'b1010: begin
          if (arf[3:2] == 2'b10) begin
            op = OP_INSERT;
          end
        end
        4'b0111: begin
          if (arf[3:1] == 3'b000) begin
            op = OP_SHUFFLE;
          end
        end
        default: op = OP_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operation datapath
  // ----------------------------------------------------------------
  bmu_word_t   sh_res, nm_res, mask, pmask, fld, ext, ins, res;
  logic        sh_lost, nm_lost, f_lost, sbit, lost_d;
  logic [15:0] exp_v;
  logic [7:0]  fw, fo, sidx;

  always_comb begin
    {sh_lost, sh_res} = bmu_shift(shv, cnt, left, logical);
    exp_v             = bmu_exp(src);
    // Negative exponent reverses into an arithmetic right shift.
    {nm_lost, nm_res} = bmu_shift(src, exp_v, 1'b1, 1'b0);
    fw    = ctl[15:8];
    fo    = ctl[7:0];
    mask  = (fw >= `BMU_FIELD_FULL) ? '1 : ((36'h1 << fw) - 36'h1);
    pmask = mask << fo;
    fld   = (src >> fo) & mask;
    sidx  = (fw > `BMU_FIELD_FULL) ? 8'(`BMU_SIGN_POS) : (fw - 8'd1);
    sbit  = (fw != 8'd0) & fld[sidx[5:0]];
    ext   = (sbit && !zext) ? (fld | ~mask) : fld;
    // Both cases reduce to the other accumulator as background: when
    // destination differs from source it is that other accumulator.
    ins    = (oth & ~pmask) | ((src << fo) & pmask);
    f_lost = (fw == 8'd0) || (({1'b0, fw} + {1'b0, fo}) > `BMU_FIELD_LIMIT);
    res    = src;
    lost_d = 1'b0;
    unique case (op)
      OP_SHIFT:   begin res = sh_res; lost_d = sh_lost; end
      OP_EXP:     begin res = {{4{exp_v[15]}}, exp_v, 16'h0}; lost_d = 1'b0; end
      OP_NORM:    begin res = nm_res; lost_d = 1'b0; end
      OP_EXTRACT: begin res = ext; lost_d = f_lost; end
      OP_INSERT:  begin res = ins; lost_d = f_lost; end
      OP_SHUFFLE: begin res = alt_q[alt_sel]; lost_d = 1'b0; end
      OP_NONE:    begin res = src; lost_d = 1'b0; end
    endcase
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic        wr_en;
  logic [7:0]  adr;
  logic [31:0] rd_d;

  assign adr   = {wb_adr_i[7:2], 2'b00};
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  // Ack comes one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      dat_q <= rd_d;
    end
  end

  always_comb begin
    rd_d = 32'h0;
    unique case (adr)
      `BMU_ADR_INSTR: rd_d = {16'h0, instr_q};
      `BMU_ADR_IMM:   rd_d = {16'h0, imm_q};
      `BMU_ADR_PSW:   rd_d = 32'({neg_q, zero_q, lost_q, guard_q}) << `BMU_PSW_GUARD_BIT;
      `BMU_ADR_ALF:   rd_d = 32'({not_ones_q, ones_q, even_q, odd_q}) << `BMU_ALF_ODD_BIT;
      default:        rd_d = 32'h0;
    endcase
    for (int i = 0; i < 2; i++) begin
      if (adr == 8'(`BMU_ADR_ACC + 8 * i))     rd_d = acc_q[i][31:0];
      if (adr == 8'(`BMU_ADR_ACC + 8 * i + 4)) rd_d = {28'h0, acc_q[i][35:32]};
      if (adr == 8'(`BMU_ADR_ALT + 8 * i))     rd_d = alt_q[i][31:0];
      if (adr == 8'(`BMU_ADR_ALT + 8 * i + 4)) rd_d = {28'h0, alt_q[i][35:32]};
    end
    for (int i = 0; i < 4; i++) begin
      if (adr == 8'(`BMU_ADR_AR + 4 * i)) rd_d = {16'h0, ar_q[i]};
    end
  end

  // Instruction and immediate words; writing the instruction launches it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_q <= 16'h0;
      imm_q   <= 16'h0;
      go_q    <= 1'b0;
    end else begin
      go_q <= wr_en && (adr == `BMU_ADR_INSTR);
      if (wr_en && (adr == `BMU_ADR_INSTR)) instr_q <= 16'(bmu_merge({16'h0, instr_q}, wb_dat_i, wb_sel_i));
      if (wr_en && (adr == `BMU_ADR_IMM))   imm_q   <= 16'(bmu_merge({16'h0, imm_q}, wb_dat_i, wb_sel_i));
    end
  end

  // ----------------------------------------------------------------
  // Register file updates
  // ----------------------------------------------------------------

  // Only the destination is written, so a distinct source survives.
  // Execution wins over the bus; the bus cannot write in that cycle anyway.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '{default: '0};
    end else if (go_q && (op != OP_NONE)) begin
      acc_q[dst] <= res;
    end else if (wr_en) begin
      for (int i = 0; i < 2; i++) begin
        if (adr == 8'(`BMU_ADR_ACC + 8 * i))
          acc_q[i][31:0] <= bmu_merge(acc_q[i][31:0], wb_dat_i, wb_sel_i);
        if (adr == 8'(`BMU_ADR_ACC + 8 * i + 4))
          acc_q[i][35:32] <= wb_sel_i[0] ? wb_dat_i[3:0] : acc_q[i][35:32];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_q <= '{default: '0};
    end else if (go_q && (op == OP_SHUFFLE)) begin
      alt_q[alt_sel] <= src;
    end else if (wr_en) begin
      for (int i = 0; i < 2; i++) begin
        if (adr == 8'(`BMU_ADR_ALT + 8 * i))
          alt_q[i][31:0] <= bmu_merge(alt_q[i][31:0], wb_dat_i, wb_sel_i);
        if (adr == 8'(`BMU_ADR_ALT + 8 * i + 4))
          alt_q[i][35:32] <= wb_sel_i[0] ? wb_dat_i[3:0] : alt_q[i][35:32];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ar_q <= '{default: '0};
    end else if (go_q && (op == OP_NORM)) begin
      ar_q[arf[1:0]] <= exp_v;
    end else if (wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (adr == 8'(`BMU_ADR_AR + 4 * i))
          ar_q[i] <= 16'(bmu_merge({16'h0, ar_q[i]}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // Flags other than the lost flag always follow the value written to the destination; the lost flag follows the operation.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {neg_q, zero_q, lost_q, guard_q} <= 4'h0;
      {even_q, odd_q, ones_q, not_ones_q} <= 4'h0;
      done_q     <= 1'b0;
      last_res_q <= '0;
    end else begin
      done_q <= go_q && (op != OP_NONE);
      if (go_q && (op != OP_NONE)) begin
        last_res_q <= res;
        neg_q      <= res[`BMU_SIGN_POS];
        zero_q     <= (res == '0);
        lost_q     <= lost_d;
        guard_q    <= !((&res[`BMU_SIGN_POS:`BMU_GUARD_LO]) ||
                        (~|res[`BMU_SIGN_POS:`BMU_GUARD_LO]));
        even_q     <= ~^res;
        odd_q      <= ^res;
        ones_q     <= &res;
        not_ones_q <= ~&res;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign wb_ack_o                = ack_q;
  assign wb_dat_o                = dat_q;
  assign shift_result_negative_o = neg_q;
  assign shift_result_zero_o     = zero_q;
  assign shift_bits_lost_o       = lost_q;
  assign shift_guard_overflow_o  = guard_q;
  assign even_parity_flag_o      = even_q;
  assign odd_parity_flag_o       = odd_q;
  assign all_ones_flag_o         = ones_q;
  assign not_all_ones_flag_o     = not_ones_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_neg_zero;
    @(posedge clk_i) disable iff (rst_i)
      done_q |-> (neg_q == last_res_q[35]) && (zero_q == (last_res_q == '0));
  endproperty
  a_neg_zero: assert property (p_neg_zero) else $error("negative or zero flag wrong");

  property p_guard;
    @(posedge clk_i) disable iff (rst_i)
      done_q |-> guard_q == (last_res_q[35:31] != 5'h00 && last_res_q[35:31] != 5'h1f);
  endproperty
  a_guard: assert property (p_guard) else $error("guard overflow flag wrong");

  property p_parity;
    @(posedge clk_i) disable iff (rst_i)
      done_q |-> (odd_q == ^last_res_q) && (even_q != odd_q);
  endproperty
  a_parity: assert property (p_parity) else $error("parity flags wrong");

  property p_ones;
    @(posedge clk_i) disable iff (rst_i)
      done_q |-> (all_ones_flag_o == (last_res_q == 36'hf_ffff_ffff)) &&
                 (not_all_ones_flag_o != all_ones_flag_o);
  endproperty
  a_ones: assert property (p_ones) else $error("all-ones flags wrong");

  property p_lrs_zero;
    @(posedge clk_i) disable iff (rst_i)
      go_q && op == OP_SHIFT && logical && !left && !cnt[15] && cnt >= 16'd32
        |=> acc_q[$past(dst)] == '0;
  endproperty
  a_lrs_zero: assert property (p_lrs_zero) else $error("long logical right shift not zero");

  property p_src_keep;
    @(posedge clk_i) disable iff (rst_i)
      go_q && op == OP_SHIFT && dst != srci |=> acc_q[~$past(dst)] == $past(acc_q[~dst]);
  endproperty
  a_src_keep: assert property (p_src_keep) else $error("shift disturbed non-destination");

  property p_exp_low;
    @(posedge clk_i) disable iff (rst_i)
      go_q && op == OP_EXP |=> acc_q[$past(dst)][15:0] == 16'h0 &&
                               acc_q[$past(dst)][31:16] == $past(exp_v);
  endproperty
  a_exp_low: assert property (p_exp_low) else $error("exponent low half not cleared");

  property p_field_lost;
    @(posedge clk_i) disable iff (rst_i)
      go_q && (op == OP_EXTRACT || op == OP_INSERT) && (fw == 8'd0)
        |=> shift_bits_lost_o && done_q;
  endproperty
  a_field_lost: assert property (p_field_lost) else $error("field lost flag missing");

  property p_shuffle;
    @(posedge clk_i) disable iff (rst_i)
      go_q && op == OP_SHUFFLE |=> alt_q[$past(alt_sel)] == $past(src) && done_q;
  endproperty
  a_shuffle: assert property (p_shuffle) else $error("shuffle alternate load wrong");

endmodule

`default_nettype wire

/* core/placeholder_none.sv */
// Intentionally minimal: holds no logic.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* testbench/bmu_core_model.sv */
// Core-side model: the decoder issuing register cycles to the unit.
`timescale 1ns/1ns
`default_nettype none

module bmu_core_model (
  // Clock.
  input  wire logic        clk_i,
  // Wishbone master side.
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle at time zero; all byte lanes are always written whole.
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0;
  end

  // One classic cycle; released data is inverted so stale values never look valid.
  task automatic cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule

`default_nettype wire

/* testbench/test_bmu_unit.sv */
// Self-checking testbench of the bit manipulation unit.
`include "bmu_params.svh"
`timescale 1ns/1ns
`default_nettype none

module test_bmu_unit;
  import bmu_pkg::*;
  localparam logic [7:0] A0 = `BMU_ADR_ACC;
  localparam logic [7:0] A1 = `BMU_ADR_ACC + 8'h08;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0] adr, xf;
  wire logic [7:0] flg;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int fail_count, num_checks, cycle_count;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  bmu_unit bmu_unit_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .shift_result_negative_o(flg[7]), .shift_result_zero_o(flg[6]),
    .shift_bits_lost_o(flg[5]), .shift_guard_overflow_o(flg[4]),
    .even_parity_flag_o(flg[3]), .odd_parity_flag_o(flg[2]),
    .all_ones_flag_o(flg[1]), .not_all_ones_flag_o(flg[0]));
  bmu_core_model bmu_core_model_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // Clock of 50 ns; the cycle ceiling cuts a hang short.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bmu_core_model_i.cycle(1'b1, a, d, q);
  endtask

  task automatic set_acc(input logic [7:0] a, input bmu_word_t v);
    wr(a, v[31:0]);
    wr(a + 8'h04, {28'h0, v[35:32]});
  endtask

  // Compares a whole 36-bit register read as two words.
  task automatic chk_acc(input string what, input logic [7:0] a, input bmu_word_t exp);
    logic [31:0] lo;
    bmu_core_model_i.cycle(1'b0, a, 32'h0, lo);
    bmu_core_model_i.cycle(1'b0, a + 8'h04, 32'h0, q);
    check(what, {q[3:0], lo}, exp);
  endtask

  // Immediate first, since the instruction consumes it when it executes.
  task automatic run(input logic d, input logic s, input logic [3:0] f4,
                     input logic [3:0] ar, input logic [15:0] imm);
    wr(`BMU_ADR_IMM, {16'h0, imm});
    wr(`BMU_ADR_INSTR, {16'h0, `BMU_TYPE_CODE, d, s, f4[3:1], 1'b0, f4[0], ar});
  endtask

  // Flags worked out from the destination value and the expected lost bit.
  function automatic logic [7:0] flags(input bmu_word_t r, input logic lost);
    flags = {r[35], r == 36'h0, lost, !(&r[35:31] || ~|r[35:31]), ~^r, ^r, &r, ~&r};
  endfunction

  task automatic expect_op(input string what, input bmu_word_t exp, input logic lost);
    chk_acc(what, A1, exp);
    check("flags", {28'h0, flg}, {28'h0, flags(exp, lost)});
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    fail_count = 0;
    num_checks = 0;
    cycle_count = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bmu_core_model_i.cycle(1'b0, 8'h40, 32'h0, q);
    check("unmapped", {4'h0, q}, 36'h0);
    set_acc(A0, 36'h8_0000_00f0);
    run(1'b1, 1'b0, 4'hc, 4'h0, 16'h0004);
    expect_op("asr", 36'hf_8000_000f, 1'b0);
    chk_acc("source", A0, 36'h8_0000_00f0);
    run(1'b1, 1'b0, 4'hc, 4'h8, 16'h0004);
    expect_op("lsr", 36'h0_0000_000f, 1'b0);
    run(1'b1, 1'b0, 4'hc, 4'h8, 16'h0020);
    expect_op("lsr32", 36'h0, 1'b0);
    run(1'b1, 1'b0, 4'hc, 4'h0, 16'h0024);
    expect_op("asr36", 36'hf_ffff_ffff, 1'b1);
    run(1'b1, 1'b0, 4'hc, 4'h0, 16'hfffc);
    expect_op("negcount", 36'h0_0000_0f00, 1'b1);
    set_acc(A0, 36'h0_0800_0000);
    run(1'b1, 1'b0, 4'hd, 4'h8, 16'h0004);
    expect_op("lsl", 36'h0_8000_0000, 1'b0);
    wr(`BMU_ADR_AR + 8'h04, 32'h4);
    run(1'b1, 1'b0, 4'h1, 4'h1, 16'h0);
    expect_op("asl", 36'h0_8000_0000, 1'b0);
    $display("test shifts done");
    set_acc(A0, 36'h0_0000_1000);
    run(1'b1, 1'b0, 4'h0, 4'hc, 16'h0);
    expect_op("exp", 36'h0_0012_0000, 1'b0);
    run(1'b1, 1'b0, 4'h1, 4'he, 16'h0);
    expect_op("norm", 36'h0_4000_0000, 1'b0);
    chk_acc("expreg", `BMU_ADR_AR + 8'h08, 36'h12);
    chk_acc("source", A0, 36'h0_0000_1000);
    set_acc(A0, 36'h0_8000_0000);
    run(1'b1, 1'b0, 4'h0, 4'hc, 16'h0);
    expect_op("negexp", 36'hf_ffff_0000, 1'b0);
    $display("test exponent done");
    set_acc(A0, 36'h0_0000_00f0);
    run(1'b1, 1'b0, 4'he, 4'h0, 16'h0304);
    expect_op("extracts", 36'hf_ffff_ffff, 1'b0);
    run(1'b1, 1'b0, 4'he, 4'h4, 16'h0304);
    expect_op("extractz", 36'h7, 1'b0);
    wr(`BMU_ADR_AR + 8'h0c, 32'h0304);
    run(1'b1, 1'b0, 4'h2, 4'h7, 16'h0);
    expect_op("extreg", 36'h7, 1'b0);
    run(1'b1, 1'b0, 4'he, 4'h4, 16'h2004);
    expect_op("fit36", 36'hf, 1'b0);
    run(1'b1, 1'b0, 4'he, 4'h4, 16'h2104);
    expect_op("over36", 36'hf, 1'b1);
    set_acc(A0, 36'hf);
    set_acc(A1, 36'h0_00fa_aabb);
    run(1'b0, 1'b0, 4'he, 4'h8, 16'h0410);
    chk_acc("insert2", A0, 36'h0_00ff_aabb);
    set_acc(A0, 36'h5);
    run(1'b1, 1'b0, 4'he, 4'h8, 16'h0410);
    expect_op("insert1", 36'h0_00f5_aabb, 1'b0);
    $display("test fields done");
    set_acc(`BMU_ADR_ALT, 36'h9_0000_0001);
    run(1'b1, 1'b0, 4'h7, 4'h0, 16'h0);
    expect_op("shuffle", 36'h9_0000_0001, 1'b0);
    chk_acc("alternate", `BMU_ADR_ALT, 36'h5);
    bmu_core_model_i.cycle(1'b0, `BMU_ADR_PSW, 32'h0, q);
    xf = flags(36'h9_0000_0001, 1'b0);
    check("status", {32'h0, q[15:12]}, {32'h0, xf[7:4]});
    bmu_core_model_i.cycle(1'b0, `BMU_ADR_ALF, 32'h0, q);
    check("auxflags", {32'h0, q[7:4]}, {32'h0, xf[0], xf[1], xf[3], xf[2]});
    wr(`BMU_ADR_INSTR, {16'h0, 5'h1f, 1'b0, 1'b0, 3'h3, 1'b0, 1'b1, 4'h0});
    expect_op("badtype", 36'h9_0000_0001, 1'b0);
    $display("test shuffle done");
    set_acc(A0, 36'h0_0004_0000);
    run(1'b1, 1'b0, 4'h9, 4'h0, 16'h0);
    expect_op("accshift", 36'h0_0000_0010, 1'b1);
    // A second reset in mid-run must clear the flags and accumulator A1 again.
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("resetflags", {28'h0, flg}, 36'h0);
    chk_acc("resetacc", A1, 36'h0);
    $display("test reset done");
    final_report();
  end
endmodule

`default_nettype wire
